// File: rtl/jaf_framer.sv
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "jaf_regs.svh"
// Behaviour
// - slope report every 10 ms, priority 3
// - pitch bytes 1-3, roll bytes 4-6
// - angles 1/32768 deg per bit, -250 offset
// - compensation fields always filled 11b
// - quality fields carry 2-bit figure of merit
// - latency byte 0.5 ms per bit
// - direction report only on request, priority 6
// - bearing, altitude 0xFFFF; speed 0xFFF
// - pitch bytes 5-6, 1/128 deg, -200 offset
// - second report on request, roll bytes 1-2
// - second report roll limited to +-90
// - at most ten routed signals per message
// - received signal updates only on arrival
// - discrete signals are 32-bit unsigned
// - discrete to continuous keeps the value
// - continuous to discrete truncates fraction
// - large continuous clamps to 0xFFFFFFFF
// - negative continuous becomes discrete zero
// - unconnected input is undefined, no signal
// - any output fans out to many inputs
module jaf_framer #(
  parameter int PERIOD_CYC = `JAF_PERIOD_CYC
) (
  input  wire logic        mclk,           // System clock, 25 MHz.
  input  wire logic        rst_n,          // Synchronous reset.
  input  wire logic [3:0]  avs_address,    // Register byte address.
  input  wire logic        avs_read,       // Read request.
  input  wire logic        avs_write,      // Write request.
  input  wire logic [3:0]  avs_byteenable, // Write byte lanes.
  input  wire logic [31:0] avs_writedata,  // Write data.
  output logic      [31:0] avs_readdata,   // Read data.
  output logic             avs_waitrequest,// Stall the master.
  input  wire logic [31:0] pitch_deg,      // Pitch, Q16 degrees.
  input  wire logic [31:0] roll_deg,       // Roll, Q16 degrees.
  input  wire logic [31:0] angle_fom,      // Figure of merit state.
  input  wire logic [31:0] latency_ms,     // Latency, Q16 ms.
  input  wire logic        rx_valid,       // Received signal strobe.
  input  wire logic [1:0]  rx_index,       // Receive block index.
  input  wire logic [31:0] rx_data,        // Received discrete value.
  input  wire logic        req_valid,      // Request strobe.
  input  wire logic [17:0] req_pgn,        // Requested group.
  output logic             tx_valid,       // Frame offered.
  input  wire logic        tx_ready,       // Frame taken.
  output logic      [2:0]  tx_prio,        // Frame priority.
  output logic      [17:0] tx_pgn,         // Frame group number.
  output logic      [3:0]  tx_dlc,         // Frame length.
  output logic      [63:0] tx_data         // Payload, byte 1 lowest.
);

  // ****************************************************************
  // Signal conversion helpers.
  // ****************************************************************

  // Delivers a discrete view of a signal with truncation and clamps.
  function automatic logic [31:0] to_disc(input jaf_pkg::jaf_sig_s s);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (s.kind == jaf_pkg::SIG_DISC)
      r = s.val[31:0];
    else if (s.kind == jaf_pkg::SIG_CONT)
    begin
      if (s.val[55])
        r = 32'h0000_0000;
      else if (s.val[54:48] != 7'h00)
        r = 32'hFFFF_FFFF;
      else
        r = s.val[47:16];
    end
    return r;
  endfunction

  // Delivers a continuous view of a signal.
  function automatic logic signed [55:0] to_cont(
    input jaf_pkg::jaf_sig_s s);
    logic signed [55:0] r;
    r = s.val;
    if (s.kind == jaf_pkg::SIG_DISC)
      r = {8'h00, s.val[31:0], 16'h0000};
    return r;
  endfunction

  // Offsets, scales and clamps a continuous value into a field.
  function automatic logic [23:0] enc(input logic signed [55:0] c,
                                      input logic signed [55:0] ofs,
                                      input logic [4:0]         sh,
                                      input logic [23:0]        mx);
    logic signed [55:0] t;
    logic signed [55:0] q;
    logic [23:0]        r;
    t = c + ofs;
    q = t >>> sh;
    r = q[23:0];
    if (t < 0)
      r = 24'h000000;
    else if (q > $signed({32'h0000_0000, mx}))
      r = mx;
    return r;
  endfunction

  // ****************************************************************
  // Register file and bus slave.
  // ****************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] route_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] count_reg;
  logic [31:0] wmask;
  logic        bus_req;
  logic        wr_fire;
  logic        sel_ctrl;
  logic        sel_route;
  logic        sel_status;
  logic [31:0] status_word;

  // Byte lane mask, address decode and the one-cycle answer.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mask
      assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign wr_fire         = avs_write & ack_reg;
  assign sel_ctrl        = avs_address == `JAF_OFS_CTRL;
  assign sel_route       = avs_address == `JAF_OFS_ROUTE;
  assign sel_status      = avs_address == `JAF_OFS_STATUS;
  assign rdata_next      = sel_ctrl   ? ctrl_reg    :
                           sel_route  ? route_reg   :
                           sel_status ? status_word : 32'h0000_0000;
  assign avs_readdata    = rdata_reg;

  // Takes each request on the second edge after it appears.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg  <= `JAF_CTRL_RST;
      route_reg <= `JAF_ROUTE_RST;
    end
    else
    begin
      ack_reg   <= bus_req & ~ack_reg;
      rdata_reg <= rdata_next;
      if (wr_fire && sel_ctrl)
        ctrl_reg <= (ctrl_reg & ~wmask) | (avs_writedata & wmask);
      if (wr_fire && sel_route)
        route_reg <= (route_reg & ~wmask) | (avs_writedata & wmask);
    end
  end

  // ****************************************************************
  // Signal sources and routing.
  // ****************************************************************
  jaf_pkg::jaf_sig_s src [8];
  logic [31:0]       rx_reg [3];
  logic [2:0]        rx_def_reg;

  // Received signal blocks hold their last value between arrivals.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rx_def_reg <= 3'h0;
    else if (rx_valid && rx_index != 2'h3)
      rx_def_reg[rx_index] <= 1'b1;
  end

  // Data of the received signal blocks, no reset needed.
  always_ff @(posedge mclk)
  begin
    if (rx_valid && rx_index != 2'h3)
      rx_reg[rx_index] <= rx_data;
  end

  // Source 0 is the unconnected input; others fan out freely.
  assign src[0] = '{jaf_pkg::SIG_UNDEF, 56'sh0};
  assign src[1] = '{jaf_pkg::SIG_CONT,
                    {{24{pitch_deg[31]}}, pitch_deg}};
  assign src[2] = '{jaf_pkg::SIG_CONT,
                    {{24{roll_deg[31]}}, roll_deg}};
  assign src[3] = '{jaf_pkg::SIG_DISC, {24'h000000, angle_fom}};
  assign src[4] = '{jaf_pkg::SIG_CONT,
                    {{24{latency_ms[31]}}, latency_ms}};
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_rx_src
      assign src[5+gi] = '{rx_def_reg[gi] ? jaf_pkg::SIG_DISC
                                           : jaf_pkg::SIG_UNDEF,
                           {24'h000000, rx_reg[gi]}};
    end
  endgenerate

  // Five routed message inputs, within the ten per message.
  jaf_pkg::jaf_sig_s in_pitch;
  jaf_pkg::jaf_sig_s in_roll;
  jaf_pkg::jaf_sig_s in_pfom;
  jaf_pkg::jaf_sig_s in_rfom;
  jaf_pkg::jaf_sig_s in_lat;
  assign in_pitch = src[route_reg[`JAF_ROUTE_PITCH +: 3]];
  assign in_roll  = src[route_reg[`JAF_ROUTE_ROLL +: 3]];
  assign in_pfom  = src[route_reg[`JAF_ROUTE_PFOM +: 3]];
  assign in_rfom  = src[route_reg[`JAF_ROUTE_RFOM +: 3]];
  assign in_lat   = src[route_reg[`JAF_ROUTE_LAT +: 3]];

  // ****************************************************************
  // Field encoding and payload assembly.
  // ****************************************************************
  logic [23:0]        ext_pitch;
  logic [23:0]        ext_roll;
  logic [23:0]        dir_pitch;
  logic [23:0]        dir_roll;
  logic [23:0]        lat_raw;
  logic [1:0]         pfom;
  logic [1:0]         rfom;
  logic [31:0]        pfom_d;
  logic [31:0]        rfom_d;
  logic signed [55:0] roll_c;
  logic signed [55:0] roll_lim;
  logic [63:0]        ext_payload;
  logic [63:0]        dir_payload;
  logic [63:0]        dir2_payload;

  // Angle fields; an undefined input sends the not-available pattern.
  assign ext_pitch = in_pitch.kind == jaf_pkg::SIG_UNDEF ? 24'hFFFFFF :
                     enc(to_cont(in_pitch), `JAF_EXT_OFS,
                         5'(`JAF_EXT_SHIFT), `JAF_EXT_MAX);
  assign ext_roll  = in_roll.kind == jaf_pkg::SIG_UNDEF ? 24'hFFFFFF :
                     enc(to_cont(in_roll), `JAF_EXT_OFS,
                         5'(`JAF_EXT_SHIFT), `JAF_EXT_MAX);
  assign dir_pitch = in_pitch.kind == jaf_pkg::SIG_UNDEF ? 24'h00FFFF :
                     enc(to_cont(in_pitch), `JAF_DIR_OFS,
                         5'(`JAF_DIR_SHIFT), `JAF_DIR_MAX);
  assign roll_c    = to_cont(in_roll);
  assign roll_lim  = roll_c > `JAF_ROLL_LIM ? `JAF_ROLL_LIM :
                     roll_c < -`JAF_ROLL_LIM ? -`JAF_ROLL_LIM :
                     roll_c;
  assign dir_roll  = in_roll.kind == jaf_pkg::SIG_UNDEF ? 24'h00FFFF :
                     enc(roll_lim, `JAF_DIR_OFS,
                         5'(`JAF_DIR_SHIFT), `JAF_DIR_MAX);
  assign lat_raw   = in_lat.kind == jaf_pkg::SIG_UNDEF ? 24'h0000FF :
                     enc(to_cont(in_lat), 56'sh0,
                         5'(`JAF_LAT_SHIFT), `JAF_LAT_MAX);

  // Quality states above three are reported as not available.
  assign pfom_d = to_disc(in_pfom);
  assign rfom_d = to_disc(in_rfom);
  assign pfom   = in_pfom.kind == jaf_pkg::SIG_UNDEF || pfom_d > 32'h3 ?
                  2'b11 : pfom_d[1:0];
  assign rfom   = in_rfom.kind == jaf_pkg::SIG_UNDEF || rfom_d > 32'h3 ?
                  2'b11 : rfom_d[1:0];

  // Payloads, byte 1 in the low lane, low byte of a field first.
  assign ext_payload  = {lat_raw[7:0], rfom, 2'b11, pfom, 2'b11,
                         ext_roll, ext_pitch};
  assign dir_payload  = {16'hFFFF, dir_pitch[15:0], `JAF_SPEED_NA,
                         16'hFFFF};
  assign dir2_payload = {48'hFFFF_FFFF_FFFF, dir_roll[15:0]};

  // ****************************************************************
  // Scheduling and transmission.
  // ****************************************************************
  jaf_pkg::jaf_tx_e   tx_state;
  logic [31:0]        tick_cnt;
  logic               period_tick;
  logic               ext_pend;
  logic               dir_pend;
  logic               dir2_pend;
  logic               req_dir;
  logic               req_dir2;
  logic               launch;
  logic               take_ext;
  logic               take_dir;
  logic               take_dir2;
  logic               tx_done;

  // Decode of requests and the launch choice, slope report first.
  assign period_tick = tick_cnt == 32'(PERIOD_CYC - 1);
  assign req_dir     = req_valid & ctrl_reg[`JAF_CTRL_REQ_BIT] &
                       (req_pgn == `JAF_PGN_DIR);
  assign req_dir2    = req_valid & ctrl_reg[`JAF_CTRL_REQ_BIT] &
                       (req_pgn == `JAF_PGN_DIR2);
  assign launch      = tx_state == jaf_pkg::TX_IDLE &&
                       (ext_pend | dir_pend | dir2_pend);
  assign take_ext    = launch & ext_pend;
  assign take_dir    = launch & ~ext_pend & dir_pend;
  assign take_dir2   = launch & ~ext_pend & ~dir_pend;
  assign tx_done     = tx_valid & tx_ready;
  assign status_word = {count_reg, 12'h000, tx_valid, dir2_pend,
                        dir_pend, ext_pend};

  // Period divider, free running.
  always_ff @(posedge mclk)
  begin
    if (!rst_n || period_tick)
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end

  // Pending flags; a new cause wins over the clear of a launch.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ext_pend  <= 1'b0;
      dir_pend  <= 1'b0;
      dir2_pend <= 1'b0;
    end
    else
    begin
      ext_pend  <= (period_tick & ctrl_reg[`JAF_CTRL_PER_BIT]) |
                   (ext_pend & ~take_ext);
      dir_pend  <= req_dir | (dir_pend & ~take_dir);
      dir2_pend <= req_dir2 | (dir2_pend & ~take_dir2);
    end
  end

  // Offers one frame and holds it until the far side takes it.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_state  <= jaf_pkg::TX_IDLE;
      tx_valid  <= 1'b0;
      tx_prio   <= 3'h0;
      tx_pgn    <= 18'h00000;
      tx_dlc    <= 4'h0;
      tx_data   <= 64'h0;
      count_reg <= 16'h0000;
    end
    else
    begin
      case (tx_state)
        jaf_pkg::TX_IDLE:
        begin
          if (launch)
          begin
            tx_state <= jaf_pkg::TX_BUSY;
            tx_valid <= 1'b1;
            tx_dlc   <= `JAF_DLC;
            tx_prio  <= take_ext ? `JAF_PRIO_EXT : `JAF_PRIO_DIR;
            tx_pgn   <= take_ext ? `JAF_PGN_EXT :
                        take_dir ? `JAF_PGN_DIR : `JAF_PGN_DIR2;
            tx_data  <= take_ext ? ext_payload :
                        take_dir ? dir_payload : dir2_payload;
          end
        end
        jaf_pkg::TX_BUSY:
        begin
          if (tx_ready)
          begin
            tx_state  <= jaf_pkg::TX_IDLE;
            tx_valid  <= 1'b0;
            count_reg <= count_reg + 16'h0001;
          end
        end
        default:
          tx_state <= jaf_pkg::TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_tx_hold_frame:
    assert property (tx_valid && !tx_ready |=>
                     tx_valid && $stable(tx_data) && $stable(tx_pgn))
    else $error("Offered frame changed before it was taken.");
  a_ext_prio_len:
    assert property (tx_valid && tx_pgn == `JAF_PGN_EXT |->
                     tx_prio == 3'h3 && tx_dlc == 4'h8)
    else $error("Slope report has wrong priority or length.");
  a_tick_sets_ext:
    assert property (period_tick && ctrl_reg[0] |=> ext_pend)
    else $error("Period tick did not schedule a slope report.");
  a_comp_not_avail:
    assert property (tx_valid && tx_pgn == `JAF_PGN_EXT |->
                     tx_data[49:48] == 2'b11 && tx_data[53:52] == 2'b11)
    else $error("Compensation fields not filled with ones.");
  a_latency_range:
    assert property (take_ext && in_lat.kind != jaf_pkg::SIG_UNDEF |=>
                     tx_data[63:56] <= 8'hFA)
    else $error("Latency byte beyond its range.");
  a_dir_on_request:
    assert property ($rose(tx_valid) && tx_pgn == `JAF_PGN_DIR |->
                     $past(dir_pend) && tx_prio == 3'h6)
    else $error("Direction report sent without a request.");
  a_dir_fill:
    assert property (tx_valid && tx_pgn == `JAF_PGN_DIR |->
                     tx_data[15:0] == 16'hFFFF &&
                     tx_data[63:48] == 16'hFFFF &&
                     tx_data[31:16] == 16'h0FFF)
    else $error("Unused direction report fields not filled.");
  a_dir2_roll_fill:
    assert property (tx_valid && tx_pgn == `JAF_PGN_DIR2 &&
                     tx_data[15:0] != 16'hFFFF |->
                     tx_data[15:0] >= 16'h3700 &&
                     tx_data[15:0] <= 16'h9100 &&
                     tx_data[63:16] == 48'hFFFF_FFFF_FFFF)
    else $error("Second report roll out of range or bad fill.");
  a_rx_hold_value:
    assert property (!rx_valid || rx_index == 2'h3 |=>
                     $stable(rx_def_reg))
    else $error("Received block changed without an arrival.");
  a_bus_answer:
    assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered in one cycle.");

  c_ext_sent: cover property (tx_done && tx_pgn == `JAF_PGN_EXT);
  c_dir_sent: cover property (tx_done && tx_pgn == `JAF_PGN_DIR);
  c_dir2_sent: cover property (tx_done && tx_pgn == `JAF_PGN_DIR2);
  c_bus_write: cover property (wr_fire && sel_route);

endmodule

// File: shared/jaf_pkg.sv
package jaf_pkg;

  // Kind of data a signal carries.
  typedef enum logic [1:0] {SIG_UNDEF, SIG_DISC, SIG_CONT} jaf_kind_e;

  // Signal value: discrete in low 32 bits, continuous as Q40.16.
  typedef struct packed {
    jaf_kind_e          kind;
    logic signed [55:0] val;
  } jaf_sig_s;

  // Transmit side state.
  typedef enum logic {TX_IDLE, TX_BUSY} jaf_tx_e;

endpackage

// File: shared/jaf_regs.svh
`ifndef JAF_REGS_SVH
`define JAF_REGS_SVH

// ****************************************************************
// Register map, field layout and reset values.
// ****************************************************************
`define JAF_OFS_CTRL       4'h0
`define JAF_OFS_ROUTE      4'h4
`define JAF_OFS_STATUS     4'h8
`define JAF_CTRL_PER_BIT   0
`define JAF_CTRL_REQ_BIT   1
`define JAF_CTRL_RST       32'h0000_0003
`define JAF_ROUTE_RST      32'h0004_3321
`define JAF_ROUTE_PITCH    0
`define JAF_ROUTE_ROLL     4
`define JAF_ROUTE_PFOM     8
`define JAF_ROUTE_RFOM     12
`define JAF_ROUTE_LAT      16

// ****************************************************************
// Message identities and priorities.
// ****************************************************************
`define JAF_PGN_EXT        18'h0F029
`define JAF_PGN_DIR        18'h0FEE8
`define JAF_PGN_DIR2       18'h0FD89
`define JAF_PRIO_EXT       3'h3
`define JAF_PRIO_DIR       3'h6
`define JAF_DLC            4'h8

// ****************************************************************
// Timing: report period and the clock rate.
// ****************************************************************
`define JAF_PERIOD_MS      10
`define JAF_MCLK_HZ        25000000
`define JAF_PERIOD_CYC     (`JAF_MCLK_HZ / 1000 * `JAF_PERIOD_MS)

// ****************************************************************
// Field scaling in 16-bit fraction fixed point.
// ****************************************************************
`define JAF_EXT_OFS        56'sh00_0000_00FA_0000
`define JAF_EXT_SHIFT      1
`define JAF_EXT_MAX        24'hFFFFFF
`define JAF_DIR_OFS        56'sh00_0000_00C8_0000
`define JAF_DIR_SHIFT      9
`define JAF_DIR_MAX        24'h00FFFF
`define JAF_ROLL_LIM       56'sh00_0000_005A_0000
`define JAF_LAT_SHIFT      15
`define JAF_LAT_MAX        24'h0000FA
`define JAF_SPEED_NA       16'h0FFF

`endif

// File: verif/jaf_can_node.sv
`timescale 1ns/100ps
// ****************************************************************
// Far-side node: takes offered frames, stalling at random.
// ****************************************************************
module jaf_can_node (
  input  wire logic        mclk,     // System clock.
  input  wire logic        rst_n,    // Synchronous reset.
  input  wire logic        slow,     // Stall at random when high.
  input  wire logic        tx_valid, // Frame offered.
  output logic             tx_ready, // Frame taken.
  input  wire logic [2:0]  tx_prio,  // Frame priority.
  input  wire logic [17:0] tx_pgn,   // Frame group number.
  input  wire logic [3:0]  tx_dlc,   // Frame length.
  input  wire logic [63:0] tx_data,  // Payload.
  output logic      [2:0]  g_prio,   // Last priority taken.
  output logic      [17:0] g_pgn,    // Last group taken.
  output logic      [3:0]  g_dlc,    // Last length taken.
  output logic      [63:0] g_data,   // Last payload taken.
  output int               g_cnt     // Frames taken.
);
  int          seed = 32'hA00D;
  logic [31:0] rnd;

  // Ready drops at random when slow; a frame is taken whole.
  always @(posedge mclk)
  begin
    rnd = $random(seed);
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      g_cnt    <= 0;
    end
    else
    begin
      tx_ready <= !slow || rnd[0];
      if (tx_valid && tx_ready)
      begin
        {g_prio, g_pgn, g_dlc, g_data} <= {tx_prio, tx_pgn, tx_dlc, tx_data};
        g_cnt <= g_cnt + 1;
      end
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
`include "jaf_regs.svh"
module tb;
  localparam int PER = 50;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, tx_dlc, g_dlc;
  logic [31:0] avs_writedata, avs_readdata, pitch_deg, roll_deg, q;
  logic [31:0] angle_fom, latency_ms, rx_data;
  logic        rx_valid, req_valid, tx_valid, tx_ready, slow;
  logic [1:0]  rx_index;
  logic [17:0] req_pgn, tx_pgn, g_pgn;
  logic [2:0]  tx_prio, g_prio;
  logic [63:0] tx_data, g_data, e;
  logic [23:0] w;
  int          g_cnt, error_cnt, checked, t0, c, i;
  int          cyc = 0;
  int          seed = 32'hA00D;
  logic [31:0] pv [3] = '{32'h0002_C000, 32'hFFFB_0000, 32'h0007_8000};
  logic [1:0]  pf [3] = '{2'h2, 2'h0, 2'h3};

  jaf_framer #(.PERIOD_CYC(PER)) i_jaf_framer (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .pitch_deg, .roll_deg, .angle_fom, .latency_ms,
    .rx_valid, .rx_index, .rx_data, .req_valid, .req_pgn, .tx_valid,
    .tx_ready, .tx_prio, .tx_pgn, .tx_dlc, .tx_data);
  jaf_can_node i_jaf_can_node (.mclk, .rst_n, .slow, .tx_valid, .tx_ready,
    .tx_prio, .tx_pgn, .tx_dlc, .tx_data, .g_prio, .g_pgn, .g_dlc, .g_data,
    .g_cnt);

  // ****************************************************************
  // Clock, expectations and shared tasks.
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Offset, scale and clamp of a Q16 value into a field.
  function automatic logic [23:0] enc(logic [31:0] d, int o, int s, int m);
    longint v;
    v = (longint'($signed(d)) + longint'(o) * 65536) >>> s;
    return (v < 0) ? 24'h0 : (v > m) ? m[23:0] : v[23:0];
  endfunction
  function automatic logic [1:0] fm(longint v);
    return (v < 0) ? 2'h0 : (v > 3) ? 2'h3 : v[1:0];
  endfunction
  function automatic logic [63:0] slope(logic [23:0] p, r, logic [1:0] a,
                                         b, logic [7:0] l);
    return {l, b, 2'h3, a, 2'h3, r, p};
  endfunction

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic fail;
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  task automatic chk(input logic [63:0] g, x);
    checked++;
    if (g !== x)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20)
      fail();
  endtask
  task automatic pulse(input logic rq, input logic [17:0] p);
    @(posedge mclk);
    req_valid <= rq;
    rx_valid  <= !rq;
    req_pgn   <= p;
    rx_index  <= p[1:0];
    rx_data   <= {14'h0, p} >> 2;
    @(posedge mclk);
    {req_valid, rx_valid} <= 2'b00;
  endtask
  task automatic wait_frame(input logic [17:0] p);
    int n;
    int k;
    k = g_cnt;
    for (n = 0; n < 800; n++)
    begin
      @(posedge mclk);
      if (g_cnt != k && g_pgn === p)
        return;
      k = g_cnt;
    end
    fail();
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    {rst_n, avs_read, avs_write, rx_valid, req_valid, slow} = '0;
    {avs_address, avs_writedata, rx_index, rx_data, req_pgn} = '0;
    {pitch_deg, roll_deg, angle_fom, latency_ms} = '0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, `JAF_OFS_CTRL, 0, q);
    chk(q, `JAF_CTRL_RST);
    bus(0, `JAF_OFS_ROUTE, 0, q);
    chk(q, `JAF_ROUTE_RST);
    bus(1, 4'hC, 32'hFFFF_FFFF, q);
    bus(0, 4'hC, 0, q);
    chk(q, 0);
    // Only the top byte lane of the routing word is written here.
    avs_byteenable <= 4'h8;
    bus(1, `JAF_OFS_ROUTE, 32'hFFFF_FFFF, q);
    avs_byteenable <= 4'hF;
    bus(0, `JAF_OFS_ROUTE, 0, q);
    chk(q, `JAF_ROUTE_RST | 32'hFF00_0000);
    // Random angles, with out-of-range corners first.
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      pitch_deg  <= i ? $random(seed) % (180 << 16) : 32'h012C_0000;
      roll_deg   <= i ? $random(seed) % (180 << 16) : 32'hFEFC_0000;
      angle_fom  <= {$random(seed)} % 6;
      latency_ms <= {$random(seed)} % (140 << 16);
      slow       <= i[0];
      wait_frame(18'd61481);
      wait_frame(18'd61481);
      e = slope(enc(pitch_deg, 250, 1, 'hFFFFFF),
                enc(roll_deg, 250, 1, 'hFFFFFF), fm(angle_fom),
                fm(angle_fom), enc(latency_ms, 0, 15, 250));
      chk(g_data, e);
      chk({g_prio, g_dlc}, {3'h3, 4'h8});
    end
    slow <= 1'b0;
    wait_frame(18'd61481);
    t0 = cyc;
    wait_frame(18'd61481);
    chk(cyc - t0, PER);
    pitch_deg <= 32'hFFE2_0000;
    pulse(1, 18'd65256);
    wait_frame(18'd65256);
    w = enc(pitch_deg, 200, 9, 'hFFFF);
    chk(g_data, {16'hFFFF, w[15:0], 16'h0FFF, 16'hFFFF});
    chk(g_prio, 6);
    for (i = 0; i < 2; i++)
    begin
      roll_deg <= i ? 32'hFF9C_0000 : 32'h0078_0000;
      pulse(1, 18'd64905);
      pulse(1, 18'd65256);
      wait_frame(18'd64905);
      w = enc(i ? 32'hFFA6_0000 : 32'h005A_0000, 200, 9, 'hFFFF);
      chk(g_data, {48'hFFFF_FFFF_FFFF, w[15:0]});
      chk(g_prio, 6);
    end
    bus(1, `JAF_OFS_CTRL, 0, q);
    repeat (PER) @(posedge mclk);
    c = g_cnt;
    pulse(1, 18'd65256);
    pulse(1, 18'd61481);
    repeat (3 * PER) @(posedge mclk);
    chk(g_cnt - c, 0);
    bus(0, `JAF_OFS_STATUS, 0, q);
    chk(q, {g_cnt[15:0], 16'h0000});
    bus(1, `JAF_OFS_CTRL, 3, q);
    // Pitch from receive block 0, latency from block 1, fan-out of pitch.
    bus(1, `JAF_OFS_ROUTE, 32'h0006_0115, q);
    wait_frame(18'd61481);
    wait_frame(18'd61481);
    chk({g_data[63:56], g_data[23:0]}, 32'hFFFF_FFFF);
    pulse(0, 18'd400);
    pulse(0, 18'd161);
    pulse(0, 18'd31);
    for (i = 0; i < 3; i++)
    begin
      pitch_deg <= pv[i];
      pulse(0, 18'd38);
      rx_data <= $random(seed);
      wait_frame(18'd61481);
      wait_frame(18'd61481);
      e = slope(24'hAF0000, enc(pv[i], 250, 1, 'hFFFFFF), pf[i], 2'h3, 8'h50);
      chk(g_data, e);
    end
    report_and_stop();
  end
endmodule
